// file: rtl/exec_core.sv
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
// execute stage for alu, compare, skip and branch ops behind axi4-lite
module exec_core
    import exec_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic        CLOCK,    // core clock, 50 MHz
    input  wire logic        RESETN,   // async reset, active low
    input  wire logic [11:0] AWADDR,   // write address
    input  wire logic        AWVALID,  // write address valid
    output logic             AWREADY,  // write address ready
    input  wire logic [31:0] WDATA,    // write data
    input  wire logic [3:0]  WSTRB,    // write byte lanes
    input  wire logic        WVALID,   // write data valid
    output logic             WREADY,   // write data ready
    output logic      [1:0]  BRESP,    // write response
    output logic             BVALID,   // write response valid
    input  wire logic        BREADY,   // write response ready
    input  wire logic [11:0] ARADDR,   // read address
    input  wire logic        ARVALID,  // read address valid
    output logic             ARREADY,  // read address ready
    output logic      [31:0] RDATA,    // read data
    output logic      [1:0]  RRESP,    // read response
    output logic             RVALID,   // read data valid
    input  wire logic        RREADY,   // read data ready
    output logic             BUSY      // instruction in flight
);
    localparam int SPW = $clog2(STACK_DEPTH);

    logic [7:0]     gpr_r [32];
    logic [7:0]     io_r [32];
    logic [15:0]    stack_r [STACK_DEPTH];
    logic [SPW-1:0] sp_r;
    logic [15:0]    pc_r;
    logic [7:0]     flags_r;
    logic [31:0]    instr_r;
    logic           next_two_r;
    logic           exec_r;
    logic [1:0]     wait_r;
    logic [1:0]     last_cyc_r;
    logic           aw_have_r;
    logic           w_have_r;
    logic [11:0]    awaddr_r;
    logic [31:0]    wdata_r;
    logic [3:0]     wstrb_r;

    logic        wr_fire;
    logic        wr_ok;
    logic        wr_gpr;
    logic        wr_io;
    logic        wr_known;
    logic [4:0]  wr_idx;
    logic        issue;
    logic        rd_fire;
    logic [31:0] rd_data;
    logic        rd_err;

    op_t         op;
    logic [4:0]  d;
    logic [4:0]  r;
    logic [2:0]  bsel;
    logic [11:0] kf;
    logic [7:0]  opd;
    logic [7:0]  ops;
    logic [7:0]  iov;
    logic [4:0]  pair_lo;
    logic [4:0]  pair_hi;
    logic [15:0] zptr;
    logic [15:0] alu_a;
    logic [15:0] alu_b;
    logic        alu_cin;
    alu_t        alu_mode;
    logic        alu_wide;
    logic [15:0] alu_res;
    logic [7:0]  alu_flags;
    logic        res_we;
    logic        word_we;
    logic [7:0]  upd_mask;
    logic        push;
    logic        skip;
    logic        br;
    logic [15:0] pc_nxt;
    logic [7:0]  flags_nxt;
    logic [1:0]  cyc_nxt;

    assign wr_fire = aw_have_r && w_have_r && !BVALID;
    assign wr_idx  = awaddr_r[6:2];
    assign wr_gpr  = (awaddr_r[11:7] == GPR_BASE[11:7]) && (awaddr_r[1:0] == 2'h0);
    assign wr_io   = (awaddr_r[11:7] == IO_BASE[11:7]) && (awaddr_r[1:0] == 2'h0);
    assign wr_known = wr_gpr || wr_io || awaddr_r == INSTR_OFS || awaddr_r == NEXT_OFS
                   || awaddr_r == PC_OFS || awaddr_r == FLAGS_OFS
                   || awaddr_r == STATUS_OFS;
    // writes are refused while an instruction runs, so no state has two writers at once
    assign wr_ok   = wr_fire && wr_known && !BUSY;
    assign issue   = wr_ok && awaddr_r == INSTR_OFS;
    assign rd_fire = ARVALID && ARREADY;

    // write address channel, taken independently of data
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            aw_have_r <= 1'b0;
            awaddr_r  <= 12'h000;
            AWREADY   <= 1'b1;
        end else if (AWVALID && AWREADY) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= AWADDR;
            AWREADY   <= 1'b0;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end else if (BVALID && BREADY) begin
            AWREADY   <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            w_have_r <= 1'b0;
            wdata_r  <= 32'h00000000;
            wstrb_r  <= 4'h0;
            WREADY   <= 1'b1;
        end else if (WVALID && WREADY) begin
            w_have_r <= 1'b1;
            wdata_r  <= WDATA;
            wstrb_r  <= WSTRB;
            WREADY   <= 1'b0;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end else if (BVALID && BREADY) begin
            WREADY   <= 1'b1;
        end
    end

    // write response: slverr for unmapped offsets and for writes while busy
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            BVALID <= 1'b0;
            BRESP  <= RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // read decode straight from the address bus
    always_comb begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        if (ARADDR[11:7] == GPR_BASE[11:7] && ARADDR[1:0] == 2'h0) begin
            rd_data[7:0] = gpr_r[ARADDR[6:2]];
        end else if (ARADDR[11:7] == IO_BASE[11:7] && ARADDR[1:0] == 2'h0) begin
            rd_data[7:0] = io_r[ARADDR[6:2]];
        end else begin
            case (ARADDR)
                INSTR_OFS:  rd_data = instr_r;
                NEXT_OFS:   rd_data[0] = next_two_r;
                PC_OFS:     rd_data[15:0] = pc_r;
                FLAGS_OFS:  rd_data[7:0] = flags_r;
                STATUS_OFS: begin
                    rd_data[STAT_BUSY] = BUSY;
                    rd_data[STAT_CYC_LO +: 2] = last_cyc_r;
                    rd_data[STAT_SP_LO +: SPW] = sp_r;
                end
                default:    rd_err = 1'b1;
            endcase
        end
    end

    // read channel, one outstanding read
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= RESP_OKAY;
        end else if (rd_fire) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_data;
            RRESP   <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (RVALID && RREADY) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
        end
    end

    // decode and execute the held instruction
    always_comb begin
        op       = op_t'(instr_r[OP_HI:OP_LO]);
        d        = instr_r[D_HI:D_LO];
        r        = instr_r[R_HI:R_LO];
        bsel     = instr_r[B_HI:B_LO];
        kf       = instr_r[K_HI:0];
        opd      = gpr_r[d];
        ops      = gpr_r[r];
        iov      = io_r[r];
        pair_lo  = {d[4:1], 1'b0};
        pair_hi  = {d[4:1], 1'b1};
        zptr     = {gpr_r[Z_HI_IDX], gpr_r[Z_LO_IDX]};
        alu_a    = {8'h00, opd};
        alu_b    = {8'h00, ops};
        alu_cin  = 1'b0;
        alu_mode = alu_add;
        alu_wide = 1'b0;
        res_we   = 1'b0;
        word_we  = 1'b0;
        upd_mask = 8'h00;
        push     = 1'b0;
        skip     = 1'b0;
        br       = 1'b0;
        pc_nxt   = pc_r + PC_STEP;
        cyc_nxt  = CYC_1;
        case (op)
            add_op, add_carry_op: begin
                alu_cin  = (op == add_carry_op) && flags_r[FLAG_C];
                res_we   = 1'b1;
                upd_mask = ARITH_MASK;
            end
            word_add_immediate_op, word_sub_immediate_op: begin
                alu_a    = {gpr_r[pair_hi], gpr_r[pair_lo]};
                alu_b    = {10'h000, kf[5:0]};
                alu_mode = (op == word_sub_immediate_op) ? alu_sub : alu_add;
                alu_wide = 1'b1;
                word_we  = 1'b1;
                upd_mask = WORD_MASK;
                cyc_nxt  = CYC_2;
            end
            sub_op, sub_with_borrow_op: begin
                alu_mode = alu_sub;
                alu_cin  = (op == sub_with_borrow_op) && flags_r[FLAG_C];
                res_we   = 1'b1;
                upd_mask = ARITH_MASK;
            end
            sub_constant_op, sub_constant_borrow_op: begin
                alu_mode = alu_sub;
                alu_b    = {8'h00, kf[7:0]};
                alu_cin  = (op == sub_constant_borrow_op) && flags_r[FLAG_C];
                res_we   = 1'b1;
                upd_mask = ARITH_MASK;
            end
            // and forms, test ands a register with itself
            and_op, and_constant_op, test_value_op: begin
                alu_mode = alu_and;
                if (op == and_constant_op) begin
                    alu_b = {8'h00, kf[7:0]};
                end else if (op == test_value_op) begin
                    alu_b = {8'h00, opd};
                end
                res_we   = 1'b1;
                upd_mask = LOGIC_MASK;
            end
            // or forms, set bits ors the mask
            or_op, or_constant_op, set_bits_op: begin
                alu_mode = alu_or;
                if (op != or_op) begin
                    alu_b = {8'h00, kf[7:0]};
                end
                res_we   = 1'b1;
                upd_mask = LOGIC_MASK;
            end
            xor_registers_op: begin
                alu_mode = alu_xor;
                res_we   = 1'b1;
                upd_mask = LOGIC_MASK;
            end
            clear_bits_op: begin
                alu_mode = alu_and;
                alu_b    = {8'h00, INV_BASE - kf[7:0]};
                res_we   = 1'b1;
                upd_mask = LOGIC_MASK;
            end
            indirect_jump_op: begin
                pc_nxt  = zptr;
                cyc_nxt = CYC_2;
            end
            relative_call_op: begin
                pc_nxt  = pc_r + {{4{kf[11]}}, kf} + PC_STEP;
                push    = 1'b1;
                cyc_nxt = CYC_3;
            end
            indirect_call_op: begin
                pc_nxt  = zptr;
                push    = 1'b1;
                cyc_nxt = CYC_3;
            end
            compare_skip_equal_op: skip = (opd == ops);
            // compares keep the register, set flags
            compare_op, compare_carry_op, compare_immediate_op: begin
                alu_mode = alu_sub;
                if (op == compare_immediate_op) begin
                    alu_b = {8'h00, kf[7:0]};
                end
                alu_cin  = (op == compare_carry_op) && flags_r[FLAG_C];
                upd_mask = ARITH_MASK;
            end
            skip_reg_bit_clear_op: skip = !ops[bsel];
            skip_reg_bit_set_op:   skip = ops[bsel];
            skip_io_bit_clear_op:  skip = !iov[bsel];
            skip_io_bit_set_op:    skip = iov[bsel];
            branch_flag_set_op:    br = flags_r[bsel];
            branch_flag_clear_op:  br = !flags_r[bsel];
            branch_equal_op:       br = flags_r[FLAG_Z];
            branch_not_equal_op:   br = !flags_r[FLAG_Z];
            branch_carry_set_op:   br = flags_r[FLAG_C];
            default: begin
                res_we = 1'b0;
            end
        endcase
        // skip length follows the skipped word count
        if (skip) begin
            pc_nxt  = pc_r + (next_two_r ? SKIP_LONG : SKIP_SHORT);
            cyc_nxt = next_two_r ? CYC_3 : CYC_2;
        end
        if (br) begin
            pc_nxt  = pc_r + {{4{kf[11]}}, kf} + PC_STEP;
            cyc_nxt = CYC_2;
        end
        flags_nxt = (flags_r & ~upd_mask) | (alu_flags & upd_mask);
    end

    exec_alu u_alu (
        .a     (alu_a),
        .b     (alu_b),
        .cin   (alu_cin),
        .mode  (alu_mode),
        .wide  (alu_wide),
        .res   (alu_res),
        .flags (alu_flags)
    );

    // instruction issue and cycle timing
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            instr_r    <= 32'h00000000;
            exec_r     <= 1'b0;
            wait_r     <= 2'h0;
            last_cyc_r <= 2'h0;
            BUSY       <= 1'b0;
        end else if (issue) begin
            instr_r <= wdata_r;
            exec_r  <= 1'b1;
            BUSY    <= 1'b1;
        end else if (exec_r) begin
            exec_r     <= 1'b0;
            wait_r     <= cyc_nxt - CYC_1;
            last_cyc_r <= cyc_nxt;
            BUSY       <= (cyc_nxt != CYC_1);
        end else if (wait_r != 2'h0) begin
            wait_r <= wait_r - CYC_1;
            BUSY   <= (wait_r != CYC_1);
        end
    end

    // register file: result commit, or a byte from software when idle
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < 32; i++) begin
                gpr_r[i] <= 8'h00;
            end
        end else if (exec_r) begin
            // test writes back the unchanged value
            if (res_we) begin
                gpr_r[d] <= alu_res[7:0];
            end
            if (word_we) begin
                gpr_r[pair_lo] <= alu_res[7:0];
                gpr_r[pair_hi] <= alu_res[15:8];
            end
        end else if (wr_ok && wr_gpr && wstrb_r[0]) begin
            gpr_r[wr_idx] <= wdata_r[7:0];
        end
    end

    // io bytes tested by the io skips, loaded by software only
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < 32; i++) begin
                io_r[i] <= 8'h00;
            end
        end else if (wr_ok && wr_io && wstrb_r[0]) begin
            io_r[wr_idx] <= wdata_r[7:0];
        end
    end

    // program counter
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            pc_r <= PC_RST;
        end else if (exec_r) begin
            pc_r <= pc_nxt;
        end else if (wr_ok && awaddr_r == PC_OFS) begin
            if (wstrb_r[0]) begin
                pc_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
                pc_r[15:8] <= wdata_r[15:8];
            end
        end
    end

    // status flags: branches, skips and jumps leave them alone via a zero mask
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            flags_r <= FLAGS_RST;
        end else if (exec_r) begin
            flags_r <= flags_nxt;
        end else if (wr_ok && awaddr_r == FLAGS_OFS && wstrb_r[0]) begin
            flags_r <= wdata_r[7:0];
        end
    end

    // next-word length hint for skips
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            next_two_r <= 1'b0;
        end else if (wr_ok && awaddr_r == NEXT_OFS && wstrb_r[0]) begin
            next_two_r <= wdata_r[0];
        end
    end

    // return stack grows upward and wraps; deep recursion overwrites old entries
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            sp_r <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_r[i] <= 16'h0000;
            end
        end else if (exec_r && push) begin
            stack_r[sp_r] <= pc_r + PC_STEP;
            sp_r          <= sp_r + {{(SPW-1){1'b0}}, 1'b1};
        end
    end
endmodule // exec_core

// file: pkg/exec_pkg.sv
// shared constants and types of the execute block
// How it works
// - add, add-carry: Z,C,N,V,H, one cycle
// - word add immediate on pair, two cycles
// - register subtract with borrow, one cycle
// - constant subtract with borrow, one cycle
// - word subtract immediate on pair, two cycles
// - and: write result, Z,N,V only
// - or: write result, Z,N,V only
// - xor: write result, Z,N,V only
// - set bits: or mask, Z,N,V
// - clear bits: and with 0xff minus mask
// - test: and with itself, writes back the unchanged value, Z,N,V
// - indirect jump: pc from Z, two cycles
// - relative call: push, pc plus k plus one
// - indirect call: push, pc from Z
// - compare skip equal, no flags
// - compares: subtract, flags only, no store
// - register bit skip on clear or set
// - io bit skip on clear or set
// - flag branch: pc plus k plus one
package exec_pkg;
    // axi byte offsets
    localparam logic [11:0] INSTR_OFS  = 12'h000;
    localparam logic [11:0] NEXT_OFS   = 12'h004;
    localparam logic [11:0] PC_OFS     = 12'h008;
    localparam logic [11:0] FLAGS_OFS  = 12'h00c;
    localparam logic [11:0] STATUS_OFS = 12'h010;
    localparam logic [11:0] GPR_BASE   = 12'h100;
    localparam logic [11:0] IO_BASE    = 12'h200;
    // instruction word fields
    localparam int OP_HI = 30;
    localparam int OP_LO = 25;
    localparam int D_HI  = 24;
    localparam int D_LO  = 20;
    localparam int R_HI  = 19;
    localparam int R_LO  = 15;
    localparam int B_HI  = 14;
    localparam int B_LO  = 12;
    localparam int K_HI  = 11;
    // status fields
    localparam int STAT_BUSY   = 0;
    localparam int STAT_CYC_LO = 4;
    localparam int STAT_SP_LO  = 8;
    // flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] ARITH_MASK = 8'h2f;
    localparam logic [7:0] WORD_MASK  = 8'h1f;
    localparam logic [7:0] LOGIC_MASK = 8'h0e;
    localparam logic [7:0] INV_BASE   = 8'hff;
    localparam logic [4:0] Z_LO_IDX   = 5'h1e;
    localparam logic [4:0] Z_HI_IDX   = 5'h1f;
    // reset values
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    // pc steps and cycle counts
    localparam logic [15:0] PC_STEP    = 16'h0001;
    localparam logic [15:0] SKIP_SHORT = 16'h0002;
    localparam logic [15:0] SKIP_LONG  = 16'h0003;
    localparam logic [1:0]  CYC_1      = 2'h1;
    localparam logic [1:0]  CYC_2      = 2'h2;
    localparam logic [1:0]  CYC_3      = 2'h3;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [5:0] {
        nop_op, add_op, add_carry_op, word_add_immediate_op, sub_op,
        sub_constant_op, sub_with_borrow_op, sub_constant_borrow_op,
        word_sub_immediate_op, and_op, and_constant_op, or_op,
        or_constant_op, xor_registers_op, set_bits_op, clear_bits_op,
        test_value_op, indirect_jump_op, relative_call_op,
        indirect_call_op, compare_skip_equal_op, compare_op,
        compare_carry_op, compare_immediate_op, skip_reg_bit_clear_op,
        skip_reg_bit_set_op, skip_io_bit_clear_op, skip_io_bit_set_op,
        branch_flag_set_op, branch_flag_clear_op, branch_equal_op,
        branch_not_equal_op, branch_carry_set_op
    } op_t;
    typedef enum logic [2:0] {
        alu_add, alu_sub, alu_and, alu_or, alu_xor
    } alu_t;
endpackage

// file: rtl/exec_alu.sv
`timescale 1ns/1ns
// byte and word arithmetic unit with full flag vector
module exec_alu
    import exec_pkg::*;
(
    input  wire logic [15:0] a,     // destination operand
    input  wire logic [15:0] b,     // source or constant
    input  wire logic        cin,   // carry or borrow in
    input  wire alu_t        mode,  // operation
    input  wire logic        wide,  // 16-bit pair op
    output logic      [15:0] res,   // result
    output logic      [7:0]  flags  // candidate flags
);
    logic [16:0] sum;
    logic [4:0]  nib;
    logic        ma;
    logic        mb;
    logic        mr;
    logic        logic_op;

    // byte ops pass zero-extended operands, so bit 8 is their carry
    always_comb begin
        sum = 17'h00000;
        nib = 5'h00;
        logic_op = 1'b0;
        case (mode)
            alu_add: begin
                sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            end
            alu_sub: begin
                sum = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
                nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            end
            alu_and: begin
                sum = {1'b0, a & b};
                logic_op = 1'b1;
            end
            alu_or: begin
                sum = {1'b0, a | b};
                logic_op = 1'b1;
            end
            alu_xor: begin
                sum = {1'b0, a ^ b};
                logic_op = 1'b1;
            end
            default: begin
                sum = 17'h00000;
            end
        endcase
        res = wide ? sum[15:0] : {8'h00, sum[7:0]};
        ma = wide ? a[15] : a[7];
        mb = wide ? b[15] : b[7];
        mr = wide ? res[15] : res[7];
        flags = 8'h00;
        flags[FLAG_C] = wide ? sum[16] : sum[8];
        flags[FLAG_Z] = (res == 16'h0000);
        flags[FLAG_N] = mr;
        flags[FLAG_H] = nib[4];
        // overflow: sign flip against like signs (add) or unlike (sub)
        if (logic_op) begin
            flags[FLAG_V] = 1'b0;
        end else if (mode == alu_sub) begin
            flags[FLAG_V] = (ma != mb) && (mr != ma);
        end else begin
            flags[FLAG_V] = (ma == mb) && (mr != ma);
        end
        flags[FLAG_S] = mr ^ flags[FLAG_V];
    end
endmodule // exec_alu

// file: testbench/prog_mem.sv
// program memory model feeding instruction words
`timescale 1ns/1ns
module prog_mem
    import exec_pkg::*;
(
    input  wire logic [2:0]  addr, // instruction index
    output logic      [31:0] word  // fetched word
);
    op_t ops [8] = '{add_op, sub_with_borrow_op, and_constant_op, xor_registers_op,
        clear_bits_op, compare_op, compare_skip_equal_op, branch_equal_op};
    assign word = {1'h0, ops[addr], 5'h01,
        (ops[addr] == compare_skip_equal_op) ? 5'h01 : 5'h02, 15'h0035};
endmodule // prog_mem

// file: testbench/exec_core_sva.sv
// bus and timing checker for the execute block
`timescale 1ns/1ns
module exec_core_sva (
    input wire logic CLOCK,   // clock
    input wire logic RESETN,  // reset
    input wire logic AWREADY, // aw ready
    input wire logic BVALID,  // b valid
    input wire logic BREADY,  // b ready
    input wire logic ARVALID, // ar valid
    input wire logic ARREADY, // ar ready
    input wire logic RVALID,  // r valid
    input wire logic RREADY,  // r ready
    input wire logic BUSY     // busy
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    busy_bound_a: assert property ($rose(BUSY) |-> ##[1:3] !BUSY)
        else $error("busy too long");
    busy_cause_a: assert property ($rose(BUSY) |-> BVALID)
        else $error("busy without write");
    b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
        else $error("b dropped");
    b_release_a: assert property (BVALID && BREADY |=> !BVALID)
        else $error("b kept");
    r_hold_a: assert property (RVALID && !RREADY |=> RVALID)
        else $error("r dropped");
    r_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("no read answer");
    aw_block_a: assert property (BVALID |-> !AWREADY)
        else $error("aw ready early");
    ar_block_a: assert property (RVALID |-> !ARREADY)
        else $error("ar ready early");
endmodule // exec_core_sva
bind exec_core exec_core_sva exec_core_sva_i (.CLOCK, .RESETN, .AWREADY, .BVALID,
    .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY, .BUSY);

// file: testbench/alu_and_branch_execute_tb.sv
// self-checking bench for the execute block
`timescale 1ns/1ns
module alu_and_branch_execute_tb;
    import exec_pkg::*;
    logic CLOCK = 0, RESETN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0;
    logic RREADY = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID, BUSY;
    logic [11:0] AWADDR = '0, ARADDR = '0;
    logic [31:0] WDATA = '0, RDATA, word, got;
    logic [1:0]  BRESP, RRESP, resp, c, f;
    logic [7:0]  a, b, r, p;
    int fail_count = 0, num_checks = 0, n, t = 0;
    always #10 CLOCK = ~CLOCK;
    exec_core exec_core_i (.CLOCK, .RESETN, .AWADDR, .AWVALID, .AWREADY, .WDATA,
        .WSTRB(4'hf), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
        .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .BUSY);
    prog_mem prog_mem_i (.addr(t[2:0]), .word);
    // expected result, pc, cycles and {C,Z}; flags enter with C clear and Z as given
    function automatic void model(op_t op, logic [7:0] a, b, logic zin, nx,
        output logic [7:0] r, p, output logic [1:0] c, f);
        r = a; p = 8'h01; c = 2'h1; f = {1'b0, zin};
        case (op)
            add_op: begin r = a + b; f[1] = r < a; end
            sub_with_borrow_op: begin r = a - b; f[1] = a < b; end
            and_constant_op: r = a & 8'h35;
            xor_registers_op: r = a ^ b;
            clear_bits_op: r = a & (8'hff - 8'h35);
            compare_op: f = {a < b, a == b};
            compare_skip_equal_op: begin
                p = 8'h02 + {7'h0, nx};
                c = 2'h2 + {1'h0, nx};
            end
            branch_equal_op: if (zin) begin p = 8'h36; c = 2'h2; end
            default: ;
        endcase
        // result-writing ops set Z from the stored byte
        if (op inside {add_op, sub_with_borrow_op, and_constant_op, xor_registers_op,
            clear_bits_op}) f[0] = (r == 8'h00);
    endfunction
    task automatic chk(string s, logic [31:0] e, g);
        num_checks++;
        if (e !== g) begin
            $display("unexpected %s: expected %h seen %h", s, e, g);
            fail_count++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // a wait that ran out of its bound ends the run
    task automatic guard;
        if (n >= 50) begin fail_count++; report_and_stop(); end
    endtask
    task automatic wr(logic [11:0] ad, logic [31:0] d);
        @(posedge CLOCK);
        AWADDR <= ad; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) break;
        end
        guard();
        BREADY <= 1'b0;
        resp = BRESP;
    endtask
    task automatic rd(logic [11:0] ad);
        @(posedge CLOCK);
        ARADDR <= ad; ARVALID <= 1'b1; RREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLOCK);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID) break;
        end
        guard();
        RREADY <= 1'b0; got = RDATA; resp = RRESP;
    endtask
    initial begin
        n = $urandom(29630);
        repeat (10) @(posedge CLOCK);
        RESETN <= 1'b1;
        rd(12'h0fc);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk("unmapped data", 32'h0, got);
        // each op runs three times with fresh operands
        for (t = 0; t < 24; t++) begin
            a = $urandom; b = $urandom;
            wr(GPR_BASE + 12'h004, {24'h0, a});
            wr(GPR_BASE + 12'h008, {24'h0, b});
            // Z toggles every eight ops and the two-word hint drops for the last pass
            wr(FLAGS_OFS, {30'h0, t[3], 1'b0});
            wr(PC_OFS, '0);
            wr(NEXT_OFS, {31'h0, !t[4]});
            wr(INSTR_OFS, word);
            chk("instr resp", {30'h0, RESP_OKAY}, {30'h0, resp});
            for (n = 0; n < 50 && (n < 1 || BUSY); n++) @(posedge CLOCK);
            guard();
            model(op_t'(word[OP_HI:OP_LO]), a, b, t[3], !t[4], r, p, c, f);
            rd(GPR_BASE + 12'h004);
            chk("result", {24'h0, r}, got);
            rd(PC_OFS);
            chk("pc", {24'h0, p}, got);
            rd(STATUS_OFS);
            chk("cycles", {30'h0, c}, {30'h0, got[5:4]});
            rd(FLAGS_OFS);
            chk("flags", {30'h0, f}, {30'h0, got[FLAG_C], got[FLAG_Z]});
        end
        report_and_stop();
    end
endmodule // alu_and_branch_execute_tb
